//--- cis_pkg.sv
package cis_pkg;

    localparam int CIS_IW         = 12;
    localparam int CIS_PCW        = 11;
    localparam int CIS_NREG       = 32;

    // 12-bit opcode patterns of the subset
    localparam logic [11:0] OP_IDLE      = 12'h000;
    localparam logic [11:0] MSK_IDLE     = 12'hFFF;
    localparam logic [11:0] OP_JUMP      = 12'hA00;
    localparam logic [11:0] MSK_JUMP     = 12'hE00;
    localparam logic [11:0] OP_INCREMENT_FILE      = 12'h280;
    localparam logic [11:0] OP_INCSZ     = 12'h3C0;
    localparam logic [11:0] OP_ORLIT     = 12'hD00;
    localparam logic [11:0] MSK_ORLIT    = 12'hF00;
    localparam logic [11:0] OP_ORFILE    = 12'h100;
    localparam logic [11:0] OP_STORE     = 12'h020;
    localparam logic [11:0] MSK_STORE    = 12'hFE0;
    localparam logic [11:0] OP_MOVE_FILE      = 12'h200;
    localparam logic [11:0] MSK_FD       = 12'hFC0;

    localparam int FLD_DEST       = 5;
    localparam int FLD_JMP_HI     = 8;
    localparam int STAT_PAGE_HI   = 6;
    localparam int STAT_PAGE_LO   = 5;
    localparam int STAT_ZERO      = 2;
    localparam logic [4:0]  STATUS_ADDR  = 5'h03;
    localparam logic [7:0]  STATUS_RST   = 8'h18;
    localparam logic [10:0] PC_RST       = 11'h000;
    localparam logic [10:0] PC_ONE       = 11'h001;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;

    typedef enum logic [3:0] {
        CIS_IDLE,
        CIS_JUMP,
        CIS_INCREMENT_FILE,
        CIS_INCSZ,
        CIS_ORLIT,
        CIS_ORFILE,
        CIS_STORE,
        CIS_MOVE_FILE,
        CIS_OTHER
    } cis_op_t;

    typedef struct packed {
        cis_op_t    op;
        logic       dest_file;
        logic [4:0] faddr;
        logic [7:0] lit;
        logic [8:0] target;
    } cis_dec_t;

endpackage : cis_pkg

//--- cis_decode.sv
`timescale 1ns/1ps
module cis_decode
    import cis_pkg::*;
(
    input  wire logic [11:0] instr_i,
    output cis_dec_t         dec_o
);

    always_comb
    begin
        dec_o.dest_file = instr_i[FLD_DEST];
        dec_o.faddr     = instr_i[4:0];
        dec_o.lit       = instr_i[7:0];
        dec_o.target    = instr_i[FLD_JMP_HI:0];
        if ((instr_i & MSK_IDLE) == OP_IDLE)
            dec_o.op = CIS_IDLE;
        else if ((instr_i & MSK_JUMP) == OP_JUMP)
            dec_o.op = CIS_JUMP;
        else if ((instr_i & MSK_ORLIT) == OP_ORLIT)
            dec_o.op = CIS_ORLIT;
        else if ((instr_i & MSK_STORE) == OP_STORE)
            dec_o.op = CIS_STORE;
        else if ((instr_i & MSK_FD) == OP_INCREMENT_FILE)
            dec_o.op = CIS_INCREMENT_FILE;
        else if ((instr_i & MSK_FD) == OP_INCSZ)
            dec_o.op = CIS_INCSZ;
        else if ((instr_i & MSK_FD) == OP_ORFILE)
            dec_o.op = CIS_ORFILE;
        else if ((instr_i & MSK_FD) == OP_MOVE_FILE)
            dec_o.op = CIS_MOVE_FILE;
        else
            dec_o.op = CIS_OTHER;
    end

endmodule : cis_decode

//--- cis_core.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Jump loads its 9-bit operand into program counter bits 8 to 0.
// RULE_02 - Jump copies status bits 6 and 5 into program counter bits 10 and 9.
// RULE_03 - Jump takes two cycles and leaves every status flag unchanged.
// RULE_04 - Increment adds one to the file register, writes destination, updates zero.
// RULE_05 - Increment-skip on zero result discards prefetched word; two cycles, no flags.
// RULE_06 - OR literal combines accumulator with literal into accumulator, updates zero.
// RULE_07 - OR file combines accumulator with file register to destination, updates zero.
// RULE_08 - Destination bit 0 selects accumulator, 1 selects the file register.
// RULE_09 - Store copies the accumulator into the file register, flags untouched.
// RULE_10 - Move file copies register to destination and updates zero flag.
// RULE_11 - Zero flag is set for an all-zero result and cleared otherwise.
// RULE_12 - Idle and other non-branching instructions finish in one cycle.
module cis_core
    import cis_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [11:0] instr_i,
    output logic      [10:0] pc_o,
    output logic      [7:0]  accum_o,
    output logic      [7:0]  status_o,
    output logic             flush_o,
    output logic             unknown_o
);

    typedef struct packed {
        logic [10:0] pc;
        logic [7:0]  accum;
        logic        flush;
        logic        refetch;
        logic        unknown;
    } cis_state_t;

    cis_state_t s_q;
    cis_state_t s_d;
    logic [7:0] regs_q [CIS_NREG];
    logic       wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    cis_dec_t   dec;
    logic [7:0] fval;
    logic [7:0] res;

    cis_decode u_decode
    (
        .instr_i (instr_i),
        .dec_o   (dec)
    );

    assign fval = regs_q[dec.faddr];

    always_comb
    begin
        s_d     = s_q;
        wr_en   = 1'b0;
        wr_addr = dec.faddr;
        wr_data = regs_q[STATUS_ADDR];
        res     = 8'h00;
        s_d.flush   = 1'b0;
        s_d.unknown = 1'b0;
        s_d.pc      = s_q.pc + PC_ONE;
        s_d.refetch = 1'b0;
        if (s_q.flush)
        begin
            // Discarded word executes as idle; after a jump the target is fetched again
            if (s_q.refetch)
                s_d.pc = s_q.pc;
        end
        else
        begin
            case (dec.op)
                CIS_JUMP:
                begin
                    // RULE_01 RULE_02 jump target
                    s_d.pc = {regs_q[STATUS_ADDR][STAT_PAGE_HI:STAT_PAGE_LO], dec.target};
                    // RULE_03 fetched word dropped
                    s_d.flush   = 1'b1;
                    s_d.refetch = 1'b1;
                end
                CIS_INCREMENT_FILE, CIS_INCSZ, CIS_ORFILE, CIS_MOVE_FILE:
                begin
                    if (dec.op == CIS_ORFILE)
                        // RULE_07 OR with file
                        res = s_q.accum | fval;
                    else if (dec.op == CIS_MOVE_FILE)
                        // RULE_10 plain copy
                        res = fval;
                    else
                        // RULE_04 add one
                        res = fval + BYTE_ONE;
                    // RULE_08 destination select
                    if (dec.dest_file)
                    begin
                        wr_en   = 1'b1;
                        wr_data = res;
                    end
                    else
                        s_d.accum = res;
                    if (dec.op == CIS_INCSZ)
                        // RULE_05 skip on zero
                        s_d.flush = (res == 8'h00);
                    else if (!(dec.dest_file && dec.faddr == STATUS_ADDR))
                    begin
                        // RULE_11 zero flag update
                        wr_en   = 1'b1;
                        wr_addr = STATUS_ADDR;
                        wr_data = regs_q[STATUS_ADDR];
                        wr_data[STAT_ZERO] = (res == 8'h00);
                    end
                    else
                        wr_data[STAT_ZERO] = (res == 8'h00);
                end
                CIS_ORLIT:
                begin
                    // RULE_06 OR literal
                    s_d.accum = s_q.accum | dec.lit;
                    wr_en   = 1'b1;
                    wr_addr = STATUS_ADDR;
                    wr_data[STAT_ZERO] = ((s_q.accum | dec.lit) == 8'h00);
                end
                CIS_STORE:
                begin
                    // RULE_09 store accumulator
                    wr_en   = 1'b1;
                    wr_data = s_q.accum;
                end
                // RULE_12 single-cycle idle
                CIS_IDLE: ;
                default: s_d.unknown = 1'b1;
            endcase
        end
    end

    // The file write port also carries the status update; the zero flag
    // update on a write-back to another file goes to the status word, and dual_wr stores the result in the file.
    // When the written file is the status word itself, the result is written with bit 2 set to the zero flag.
    logic dual_wr;
    assign dual_wr = wr_en && wr_addr == STATUS_ADDR && dec.dest_file
                     && dec.faddr != STATUS_ADDR && !s_q.flush
                     && dec.op != CIS_INCSZ
                     && (dec.op == CIS_INCREMENT_FILE || dec.op == CIS_ORFILE || dec.op == CIS_MOVE_FILE);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_q.pc      <= PC_RST;
            s_q.accum   <= 8'h00;
            s_q.flush   <= 1'b0;
            s_q.refetch <= 1'b0;
            s_q.unknown <= 1'b0;
            for (int i = 0; i < CIS_NREG; i++)
                regs_q[i] <= 8'h00;
            regs_q[STATUS_ADDR] <= STATUS_RST;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
            if (wr_en)
                regs_q[wr_addr] <= wr_data;
            if (dual_wr)
                regs_q[dec.faddr] <= res;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pc_o      <= PC_RST;
            accum_o   <= 8'h00;
            status_o  <= STATUS_RST;
            flush_o   <= 1'b0;
            unknown_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pc_o      <= s_d.pc;
            accum_o   <= s_d.accum;
            status_o  <= (wr_en && wr_addr == STATUS_ADDR) ? wr_data : regs_q[STATUS_ADDR];
            flush_o   <= s_d.flush;
            unknown_o <= s_d.unknown;
        end
    end

endmodule : cis_core

//--- cis_core_chk.sv
`timescale 1ns/1ps
module cis_core_chk (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        ce_i,
    input wire logic [11:0] instr_i,
    input wire logic [10:0] pc_o,
    input wire logic [7:0]  accum_o,
    input wire logic [7:0]  status_o,
    input wire logic        flush_o,
    input wire logic        unknown_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Word actually executed at this edge
    wire logic run = ce_i && !flush_o;

    jump_target_a: assert property (run && instr_i[11:9] == 3'h5 |=>
        pc_o == {$past(status_o[6:5]), $past(instr_i[8:0])}) else $error("jump target wrong");
    jump_flags_a: assert property (run && instr_i[11:9] == 3'h5 |=>
        flush_o && status_o == $past(status_o)) else $error("jump flags or flush wrong");
    or_literal_a: assert property (run && instr_i[11:8] == 4'hD |=>
        accum_o == ($past(accum_o) | $past(instr_i[7:0])) && status_o[2] == (accum_o == 8'h00))
        else $error("or literal wrong");
    store_flags_a: assert property (run && instr_i[11:5] == 7'h01 && instr_i[4:0] != 5'h03 |=>
        status_o == $past(status_o) && accum_o == $past(accum_o)) else $error("store changed state");
    idle_step_a: assert property (run && instr_i == 12'h000 |=>
        pc_o == $past(pc_o) + 11'h001 && !flush_o && $stable(accum_o)) else $error("idle step wrong");
    flush_ignore_a: assert property (ce_i && flush_o |=>
        !flush_o && $stable(accum_o) && $stable(status_o)) else $error("discarded word executed");
    skip_flags_a: assert property (run && instr_i[11:6] == 6'h0F && instr_i[4:0] != 5'h03 |=>
        status_o[2] == $past(status_o[2])) else $error("skip touched zero flag");
    zero_accum_a: assert property (run && instr_i[11:5] inside {7'h14, 7'h08, 7'h10} |=>
        status_o[2] == (accum_o == 8'h00)) else $error("zero flag wrong");
    jump_refetch_a: assert property (run && instr_i[11:9] == 3'h5 ##1 ce_i |=>
        pc_o == $past(pc_o)) else $error("jump target not fetched again");
    unknown_idle_a: assert property (run && instr_i[11:8] == 4'hF |=>
        unknown_o && $stable(accum_o) && $stable(status_o)) else $error("unknown opcode changed state");
endmodule : cis_core_chk

bind cis_core cis_core_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .instr_i(instr_i),
    .pc_o(pc_o), .accum_o(accum_o), .status_o(status_o), .flush_o(flush_o), .unknown_o(unknown_o));

//--- cis_pmem.sv
`timescale 1ns/1ps
// Program memory, read combinationally at the fetch address
module cis_pmem (
    input  wire logic [10:0] pc_i,
    output logic      [11:0] instr_o
);
    logic [11:0] mem [2048];
    assign instr_o = mem[pc_i];
endmodule : cis_pmem

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_i  = 1'b0;
    logic        srst_i = 1'b1;
    logic        ce_i   = 1'b1;
    logic [11:0] instr_i;
    logic [10:0] pc_o;
    logic [7:0]  accum_o;
    logic [7:0]  status_o;
    logic        flush_o;
    logic        unknown_o;
    int          failures = 0;
    int          compares = 0;
    int          cycles   = 0;

    always #4 clk_i = ~clk_i;
    cis_pmem u_mem (.pc_i(pc_o), .instr_o(instr_i));
    cis_core uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .instr_i(instr_i), .pc_o(pc_o),
        .accum_o(accum_o), .status_o(status_o), .flush_o(flush_o), .unknown_o(unknown_o));

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    // Reset, load a program at address 0, release
    task automatic go(input logic [11:0] p[$]);
        @(posedge clk_i);
        srst_i <= 1'b1;
        foreach (u_mem.mem[i]) u_mem.mem[i] <= (i < p.size()) ? p[i] : 12'h000;
        @(posedge clk_i);
        srst_i <= 1'b0;
    endtask : go

    task automatic s_data_ops;
        logic [11:0] p[$] = '{12'hD00, 12'hDFF, 12'h021, 12'h202, 12'h281, 12'h2A1, 12'hD5A, 12'h121,
                               12'h202, 12'h221, 12'h201, 12'h102, 12'hF00};
        logic [7:0]  a[$] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h00,
                               8'h5A, 8'h5A, 8'h5A};
        logic        z[$] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
                               1'b0};
        go(p);
        foreach (p[i])
        begin
            step(1);
            chk("accum", {4'h0, a[i]}, {4'h0, accum_o});
            chk("zero", {11'h000, z[i]}, {11'h000, status_o[2]});
            chk("pc", 12'(i + 1), {1'b0, pc_o});
            chk("unknown", {11'h000, i == 12}, {11'h000, unknown_o});
        end
    endtask : s_data_ops

    task automatic s_jump;
        go('{12'hD60, 12'h023, 12'hBFE});
        step(3);
        chk("jump pc", 12'h7FE, {1'b0, pc_o});
        chk("jump status", 12'h060, {4'h0, status_o});
        chk("jump flush", 12'h001, {11'h000, flush_o});
        step(1);
        chk("after jump", 12'h7FE, {flush_o, pc_o});
        step(1);
        chk("target run", 12'h7FF, {flush_o, pc_o});
    endtask : s_jump

    task automatic s_skip;
        go('{12'hDFF, 12'h021, 12'h3C1, 12'hD0F, 12'h3E2, 12'h202});
        ce_i <= 1'b0;
        step(3);
        chk("frozen pc", 12'h000, {1'b0, pc_o});
        @(posedge clk_i) ce_i <= 1'b1;
        step(3);
        chk("skip", 12'h100, {3'h0, flush_o, accum_o});
        chk("skip zero", 12'h000, {11'h000, status_o[2]});
        step(1);
        chk("discard", 12'h000, {3'h0, flush_o, accum_o});
        step(2);
        chk("no skip", 12'h001, {3'h0, flush_o, accum_o});
    endtask : s_skip

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            final_report();
        end
    end

    initial
    begin
        step(10);
        s_data_ops();
        s_jump();
        s_skip();
        final_report();
    end
endmodule : testbench
